// ==== itm_map.vh ====
// constants for the four-channel interval timer block
`ifndef ITM_MAP_VH
`define ITM_MAP_VH

// timing
`define ITM_CLK_MHZ        50
`define ITM_TICK_US        100
`define ITM_MIN_PERIOD_US  500
`define ITM_MIN_TICKS      ((`ITM_MIN_PERIOD_US + `ITM_TICK_US - 1) / `ITM_TICK_US)

// command and mode codes
`define ITM_CODE_NULL      16'h0000
`define ITM_CODE_ONESHOT   16'h1000
`define ITM_CODE_PERIODIC  16'h1001
`define ITM_CODE_FREERUN   16'h1002
`define ITM_CODE_HALT      16'h1003
`define ITM_CODE_CLEAR     16'h1004
`define ITM_CODE_STATUS    16'h001C

// targets: 0..3 single timers, 4 and 5 cascaded pairs
`define ITM_TGT_PAIR_LOW   3'h4
`define ITM_TGT_PAIR_HIGH  3'h5

// period limits
`define ITM_MAX_SINGLE     32'h0000FFFF
`define ITM_MAX_PAIR       32'hFFFFFFFF

`endif

// ==== itm_top.v ====
// four interval timers with cascading, command port and status readback
`timescale 1ns/10ps
`include "itm_map.vh"

// command port: taken on a rising edge with cmd_valid high
// answer one cycle later: cmd_done or cmd_error, plus rsp_valid for status
// a plain read answers with rsp_valid only, signal and period zero
// targets 0..3 are single timers, 4 and 5 the cascaded pairs
// a pair keeps its whole 32-bit count in the low member;
// the high member idles, so the low-half wrap carries for free
// addressing a pair in the other grouping drops both members to null
// first; a status or read never regroups, it shows the low member as is
// ticks reach channels 0..3 one cycle apart, so no two events collide
// hence TICK_CYCLES must stay at 4 or more
// a one-shot stops with its count left at the period
// a command on a channel wins over that channel's tick in the same cycle;
// the lost tick is the price of never racing a halt against an event
// free-run is accepted from any mode and cancels a pending signal
// limitation: one command per cycle, there is no queue
// limitation: a read and a status in one cycle give the status answer
// unknown codes and targets 6 and 7 are refused, state unchanged

module itm_top #(
    parameter TICK_CYCLES = `ITM_TICK_US * `ITM_CLK_MHZ  // clocks per 100 us tick
) (
    input  wire        clk,         // 50 MHz system clock
    input  wire        rst_n,       // async reset, active low
    input  wire        cmd_valid,   // one-cycle command strobe
    input  wire [15:0] cmd_code,    // command or status request code
    input  wire [2:0]  cmd_target,  // 0..3 single, 4/5 cascaded pair
    input  wire [31:0] cmd_signal,  // signal code for arming commands
    input  wire [31:0] cmd_period,  // period in ticks for arming commands
    input  wire        read_req,    // one-cycle value read strobe
    output reg         cmd_done,    // command accepted pulse
    output reg         cmd_error,   // parameter error pulse
    output reg         rsp_valid,   // response fields valid pulse
    output reg  [31:0] rsp_value,   // count in ticks
    output reg  [15:0] rsp_mode,    // mode code
    output reg  [31:0] rsp_signal,  // pending signal code
    output reg  [31:0] rsp_period,  // reported period
    output reg         evt_valid,   // timer event pulse
    output reg  [2:0]  evt_target,  // timer or pair that fired
    output reg  [31:0] evt_signal   // signal code of the event
);

    // one-hot channel states
    localparam [5:0] ST_NULL = 6'h01;
    localparam [5:0] ST_ONE  = 6'h02;
    localparam [5:0] ST_PER  = 6'h04;
    localparam [5:0] ST_FREE = 6'h08;
    localparam [5:0] ST_STOP = 6'h10;
    localparam [5:0] ST_RST  = 6'h20;
    // cut to the prescaler width on purpose; a tick never needs more than 13 bits
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    localparam [12:0] TICK_LAST   = TICK_LAST_W[12:0];
    localparam [31:0] MIN_TICKS = `ITM_MIN_TICKS;

    reg  [12:0] presc;              // prescaler count
    reg  [3:0]  tick_sr;            // tick staggered one cycle per channel
    reg  [5:0]  mode [0:3];         // channel state
    reg  [31:0] cnt  [0:3];         // channel count, 32 bits for pairs
    reg  [31:0] sig  [0:3];         // pending signal code
    reg  [31:0] per  [0:3];         // programmed period
    reg  [1:0]  pair;               // cascade flag per pair
    integer     i;                  // channel loop index
    integer     k;                  // channel loop index, decode side
    reg  [3:0]  cmd_owns;           // channels a command rewrites this cycle

    // mode state to reported code
    function [15:0] mode_code;
        input [5:0] m;
        begin
            case (m)
                ST_ONE:  mode_code = `ITM_CODE_ONESHOT;
                ST_PER:  mode_code = `ITM_CODE_PERIODIC;
                ST_FREE: mode_code = `ITM_CODE_FREERUN;
                ST_STOP: mode_code = `ITM_CODE_HALT;
                ST_RST:  mode_code = `ITM_CODE_CLEAR;
                default: mode_code = `ITM_CODE_NULL;
            endcase
        end
    endfunction

    // channel wrap limit: 32 bits only for the low member of a pair
    function [31:0] ch_limit;
        input [1:0] ch;
        input [1:0] pr;
        begin
            if (!ch[0] && pr[ch[1]]) begin
                ch_limit = `ITM_MAX_PAIR;
            end else begin
                ch_limit = `ITM_MAX_SINGLE;
            end
        end
    endfunction

    // command target decode
    wire        tgt_ok   = (cmd_target <= `ITM_TGT_PAIR_HIGH);
    wire        tgt_pair = (cmd_target == `ITM_TGT_PAIR_LOW) ||
                           (cmd_target == `ITM_TGT_PAIR_HIGH);
    wire [1:0]  tgt_ch   = tgt_pair ? {cmd_target[0], 1'b0} : cmd_target[1:0];
    wire        tgt_pi   = tgt_ch[1];                   // pair index
    wire [31:0] tgt_lim  = tgt_pair ? `ITM_MAX_PAIR : `ITM_MAX_SINGLE;
    wire        regroup  = (pair[tgt_pi] != tgt_pair);  // pairing changes
    wire        arm_cmd  = (cmd_code == `ITM_CODE_ONESHOT) ||
                           (cmd_code == `ITM_CODE_PERIODIC);
    // range and signal checks for arming commands
    wire        per_bad  = (cmd_period < MIN_TICKS) ||
                           (cmd_period > tgt_lim);
    wire        sig_bad  = (cmd_signal == 32'h00000000);
    wire [5:0]  tgt_mode = mode[tgt_ch];
    // an accepted mode command rewrites its channel, and on a regroup both
    // members; their tick is dropped so a halt or re-arm never races an event
    wire        cmd_takes = cmd_valid && tgt_ok &&
                            ((arm_cmd && !per_bad && !sig_bad) ||
                             (cmd_code == `ITM_CODE_FREERUN) ||
                             (cmd_code == `ITM_CODE_HALT) ||
                             (cmd_code == `ITM_CODE_CLEAR));

    // per-channel mask of the command's reach
    always @* begin
        cmd_owns = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (cmd_takes && (k[1] == tgt_pi) &&
                (regroup || (k[1:0] == tgt_ch))) begin
                cmd_owns[k] = 1'b1;
            end
        end
    end

    // prescaler: one tick pulse every 100 us, then staggered per channel
    // so two channels never fire an event in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc   <= 13'h0000;
            tick_sr <= 4'h0;
        end else begin
            if (presc == TICK_LAST) begin
                presc <= 13'h0000;
            end else begin
                presc <= presc + 13'h0001;
            end
            tick_sr <= {tick_sr[2:0], (presc == TICK_LAST)};
        end
    end

    // channel state, command handling and responses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                mode[i] <= ST_NULL;
                cnt[i]  <= 32'h00000000;
                sig[i]  <= 32'h00000000;
                per[i]  <= 32'h00000000;
            end
            pair       <= 2'h0;
            cmd_done   <= 1'b0;
            cmd_error  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_value  <= 32'h00000000;
            rsp_mode   <= 16'h0000;
            rsp_signal <= 32'h00000000;
            rsp_period <= 32'h00000000;
            evt_valid  <= 1'b0;
            evt_target <= 3'h0;
            evt_signal <= 32'h00000000;
        end else begin
            cmd_done  <= 1'b0;
            cmd_error <= 1'b0;
            rsp_valid <= 1'b0;
            evt_valid <= 1'b0;

            // tick processing; the high member of a pair stays idle,
            // and a channel under command skips its tick
            for (i = 0; i < 4; i = i + 1) begin
                if (tick_sr[i] && !(i[0] && pair[i >> 1]) && !cmd_owns[i]) begin
                    case (mode[i])
                        // one-shot: fire once at the period, then stop
                        ST_ONE: begin
                            if (cnt[i] + 32'h00000001 == per[i]) begin
                                cnt[i]  <= per[i];
                                mode[i] <= ST_STOP;
                                sig[i]  <= 32'h00000000;
                                evt_valid  <= 1'b1;
                                evt_signal <= sig[i];
                                evt_target <= pair[i >> 1] ?
                                              (`ITM_TGT_PAIR_LOW + i[2:0] / 3'h2) : i[2:0];
                            end else begin
                                cnt[i] <= cnt[i] + 32'h00000001;
                            end
                        end
                        // periodic: fire and restart from zero every period
                        ST_PER: begin
                            if (cnt[i] + 32'h00000001 == per[i]) begin
                                cnt[i]     <= 32'h00000000;
                                evt_valid  <= 1'b1;
                                evt_signal <= sig[i];
                                evt_target <= pair[i >> 1] ?
                                              (`ITM_TGT_PAIR_LOW + i[2:0] / 3'h2) : i[2:0];
                            end else begin
                                cnt[i] <= cnt[i] + 32'h00000001;
                            end
                        end
                        ST_FREE: begin
                            // wraps at the channel maximum; in a pair the low
                            // member counts the whole 32 bits, the high member stays idle
                            if (cnt[i] == ch_limit(i[1:0], pair)) begin
                                cnt[i] <= 32'h00000000;
                            end else begin
                                cnt[i] <= cnt[i] + 32'h00000001;
                            end
                        end
                        // remaining modes keep their count
                        default: begin
                            cnt[i] <= cnt[i];  // null, stop, reset hold
                        end
                    endcase
                end
            end

            // commands override a same-cycle tick on the addressed channel
            if (cmd_valid) begin
                if (!tgt_ok) begin
                    cmd_error <= 1'b1;
                end else if (cmd_code == `ITM_CODE_STATUS) begin
                    cmd_done   <= 1'b1;
                    rsp_valid  <= 1'b1;
                    rsp_mode   <= mode_code(tgt_mode);
                    rsp_value  <= cnt[tgt_ch];
                    if (tgt_mode == ST_ONE || tgt_mode == ST_PER) begin
                        rsp_signal <= sig[tgt_ch];
                        rsp_period <= per[tgt_ch];
                    end else if (tgt_mode == ST_FREE) begin
                        rsp_signal <= 32'h00000000;
                        rsp_period <= ch_limit(tgt_ch, pair);  // channel's own max
                    end else begin
                        rsp_signal <= 32'h00000000;
                        rsp_period <= 32'h00000000;
                    end
                end else if (arm_cmd && (per_bad || sig_bad)) begin
                    cmd_error <= 1'b1;
                end else if (arm_cmd || cmd_code == `ITM_CODE_FREERUN ||
                             cmd_code == `ITM_CODE_HALT ||
                             cmd_code == `ITM_CODE_CLEAR) begin
                    cmd_done <= 1'b1;
                    // regrouping a pair drops both members to null first;
                    // later assignments below still win for the target
                    if (regroup) begin
                        pair[tgt_pi] <= tgt_pair;
                        for (i = 0; i < 4; i = i + 1) begin
                            if (i[1] == tgt_pi) begin
                                mode[i] <= ST_NULL;
                                cnt[i]  <= 32'h00000000;
                                sig[i]  <= 32'h00000000;
                                per[i]  <= 32'h00000000;
                            end
                        end
                    end
                    if (cmd_code == `ITM_CODE_ONESHOT) begin
                        mode[tgt_ch] <= ST_ONE;
                        cnt[tgt_ch]  <= 32'h00000000;
                        sig[tgt_ch]  <= cmd_signal;
                        per[tgt_ch]  <= cmd_period;
                    end else if (cmd_code == `ITM_CODE_PERIODIC) begin
                        mode[tgt_ch] <= ST_PER;
                        cnt[tgt_ch]  <= 32'h00000000;
                        sig[tgt_ch]  <= cmd_signal;
                        per[tgt_ch]  <= cmd_period;
                    end else if (cmd_code == `ITM_CODE_FREERUN) begin
                        mode[tgt_ch] <= ST_FREE;
                        sig[tgt_ch]  <= 32'h00000000;
                        if (!regroup) begin
                            cnt[tgt_ch] <= cnt[tgt_ch];  // resumes from value
                        end
                    end else if (cmd_code == `ITM_CODE_HALT) begin
                        mode[tgt_ch] <= ST_STOP;
                        sig[tgt_ch]  <= 32'h00000000;
                        if (!regroup) begin
                            cnt[tgt_ch] <= cnt[tgt_ch];  // held count
                        end
                    end else begin
                        mode[tgt_ch] <= ST_RST;
                        cnt[tgt_ch]  <= 32'h00000000;
                        sig[tgt_ch]  <= 32'h00000000;
                    end
                end else begin
                    cmd_error <= 1'b1;  // unknown code
                end
            end

            // plain value read; a status request in the same cycle wins
            if (read_req && !(cmd_valid && cmd_code == `ITM_CODE_STATUS)) begin
                // a read of a bad target answers like a refused command
                if (!tgt_ok) begin
                    cmd_error <= 1'b1;
                end else begin
                    rsp_valid  <= 1'b1;
                    rsp_value  <= cnt[tgt_ch];
                    rsp_mode   <= mode_code(tgt_mode);
                    rsp_signal <= 32'h00000000;
                    rsp_period <= 32'h00000000;
                end
            end
        end
    end

endmodule // itm_top

// ==== itm_filler_none.v ====
// no further modules; all logic is in itm_top

// ==== itm_checker_sva.sv ====
// port-level checker for the interval timer block
`timescale 1ns/10ps
`include "itm_map.vh"
module itm_checker #(
    parameter TICK_CYCLES = 5000  // clocks per tick, handed on from the design
) (
    input wire        clk,        // system clock
    input wire        rst_n,      // async reset, active low
    input wire        cmd_valid,  // command strobe
    input wire [15:0] cmd_code,   // command code
    input wire [2:0]  cmd_target, // timer or pair
    input wire [31:0] cmd_signal, // signal code
    input wire [31:0] cmd_period, // period in ticks
    input wire        read_req,   // value read strobe
    input wire        cmd_done,   // accepted pulse
    input wire        cmd_error,  // rejected pulse
    input wire        rsp_valid,  // response pulse
    input wire [31:0] rsp_value,  // count
    input wire [15:0] rsp_mode,   // mode code
    input wire [31:0] rsp_signal, // pending signal
    input wire [31:0] rsp_period, // reported period
    input wire        evt_valid,  // event pulse
    input wire [2:0]  evt_target, // event source
    input wire [31:0] evt_signal  // event signal code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // arming commands are the only ones that check period and signal
    wire arm = cmd_valid && (cmd_code == `ITM_CODE_ONESHOT || cmd_code == `ITM_CODE_PERIODIC);

    cmd_answer_a: assert property (cmd_valid |=> cmd_done ^ cmd_error)
        else $error("command got no single answer");
    short_period_a: assert property (
        arm && cmd_period < 32'h00000005 |=> cmd_error)
        else $error("short period accepted");
    single_max_a: assert property (
        arm && cmd_target < 3'h4 && cmd_period > 32'h0000FFFF |=> cmd_error)
        else $error("oversize single period accepted");
    zero_signal_a: assert property (
        arm && cmd_signal == 32'h00000000 |=> cmd_error && !cmd_done)
        else $error("zero signal accepted");
    status_rsp_a: assert property (
        cmd_valid && cmd_code == `ITM_CODE_STATUS && cmd_target < 3'h6
        |=> rsp_valid && cmd_done)
        else $error("status gave no response");
    read_rsp_a: assert property (
        read_req && !cmd_valid && cmd_target < 3'h6
        |=> rsp_valid && rsp_signal == 32'h00000000 && rsp_period == 32'h00000000)
        else $error("value read response wrong");
    null_zero_a: assert property (
        rsp_valid && (rsp_mode == `ITM_CODE_NULL || rsp_mode == `ITM_CODE_CLEAR)
        |-> rsp_value == 32'h00000000 && rsp_period == 32'h00000000 &&
            rsp_signal == 32'h00000000)
        else $error("null or reset status not zero");
    stop_zero_a: assert property (
        rsp_valid && rsp_mode == `ITM_CODE_HALT
        |-> rsp_period == 32'h00000000 && rsp_signal == 32'h00000000)
        else $error("stop status period or signal nonzero");
    free_period_a: assert property (
        rsp_valid && cmd_done && rsp_mode == `ITM_CODE_FREERUN
        |-> rsp_signal == 32'h00000000 &&
            (rsp_period == `ITM_MAX_SINGLE || rsp_period == `ITM_MAX_PAIR))
        else $error("free-run status period wrong");
    sig_pending_a: assert property (
        rsp_valid && rsp_signal != 32'h00000000
        |-> rsp_mode == `ITM_CODE_ONESHOT || rsp_mode == `ITM_CODE_PERIODIC)
        else $error("signal reported with nothing pending");
    evt_signal_a: assert property (
        evt_valid |-> evt_signal != 32'h00000000 && evt_target < 3'h6)
        else $error("event with zero signal");
endmodule // itm_checker

// ==== interval_timer_modes_tb_top.sv ====
// self-checking testbench for the interval timer block
`timescale 1ns/10ps
`include "itm_map.vh"
module interval_timer_modes_tb_top;
    localparam T = 8;  // short tick keeps the run brief
    reg clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, read_req = 1'b0;  // control inputs
    reg [15:0] cmd_code = 16'h0;   // command code
    reg [2:0]  cmd_target = 3'h0;  // target
    reg [31:0] cmd_signal = 32'h0, cmd_period = 32'h0;  // arming fields
    wire cmd_done, cmd_error, rsp_valid, evt_valid;  // pulses
    wire [31:0] rsp_value, rsp_signal, rsp_period, evt_signal;  // data
    wire [15:0] rsp_mode;  // mode code
    wire [2:0]  evt_target;  // event source
    integer n_mismatch = 0, total_checks = 0, n;  // counters and wait length
    reg [31:0] held;  // count seen by a value read
    reg [31:0] prev;  // count before a free run
    itm_top #(.TICK_CYCLES(T)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_target(cmd_target), .cmd_signal(cmd_signal),
        .cmd_period(cmd_period), .read_req(read_req), .cmd_done(cmd_done),
        .cmd_error(cmd_error), .rsp_valid(rsp_valid), .rsp_value(rsp_value),
        .rsp_mode(rsp_mode), .rsp_signal(rsp_signal), .rsp_period(rsp_period),
        .evt_valid(evt_valid), .evt_target(evt_target), .evt_signal(evt_signal));
    always #10 clk = ~clk;  // 50 MHz
    // compare and count
    task chk(input string nm, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL %0s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle command, unused fields back to zero; answer sampled after it lands
    task cmd(input [15:0] c, input [2:0] t, input [31:0] s, input [31:0] p);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_target <= t;
        cmd_signal <= s;
        cmd_period <= p;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_signal <= 32'h0;
        cmd_period <= 32'h0;
        #1;
    endtask
    // command expected to be accepted (e=0) or refused (e=1)
    task act(input [15:0] c, input [2:0] t, input [31:0] s, input [31:0] p, input e);
        cmd(c, t, s, p);
        chk("cmd_error", e, cmd_error);
        chk("cmd_done", !e, cmd_done);
    endtask
    // status request; value all ones means not compared
    task st(input [2:0] t, input [15:0] m, input [31:0] v, input [31:0] s, input [31:0] p);
        cmd(`ITM_CODE_STATUS, t, 32'h0, 32'h0);
        chk("rsp_valid", 1, rsp_valid);
        chk("rsp_mode", m, rsp_mode);
        if (v != 32'hFFFFFFFF) begin
            chk("rsp_value", v, rsp_value);
        end
        chk("rsp_signal", s, rsp_signal);
        chk("rsp_period", p, rsp_period);
    endtask
    // value read through its own strobe
    task rd(input [2:0] t);
        @(posedge clk);
        read_req <= 1'b1;
        cmd_target <= t;
        @(posedge clk);
        read_req <= 1'b0;
        #1;
        chk("read_valid", 1, rsp_valid);
        held = rsp_value;
    endtask
    // bounded wait for the next event pulse
    task wait_evt;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n = n + 1;
        end while (evt_valid !== 1'b1 && n < 3000);
        chk("evt_valid", 1, evt_valid);  // a missing event counts here
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) st(i[2:0], `ITM_CODE_NULL, 0, 0, 0);
        $display("test reset state done");
        // refusals leave the timer untouched
        act(`ITM_CODE_ONESHOT, 3'h0, 32'h7, 32'h4, 1);
        act(`ITM_CODE_PERIODIC, 3'h1, 32'h7, 32'h10000, 1);
        act(`ITM_CODE_ONESHOT, 3'h0, 32'h0, 32'h5, 1);
        act(`ITM_CODE_PERIODIC, 3'h6, 32'h7, 32'h5, 1);
        st(3'h0, `ITM_CODE_NULL, 0, 0, 0);
        $display("test refusals done");
        // one-shot at the minimum period, then falls into stop
        act(`ITM_CODE_ONESHOT, 3'h0, 32'h7, 32'h5, 0);
        wait_evt;
        chk("oneshot_time", 1, n >= 4 * T && n <= 5 * T + 1);
        chk("evt_target", 0, evt_target);
        chk("evt_signal", 7, evt_signal);
        st(3'h0, `ITM_CODE_HALT, 5, 0, 0);
        $display("test one-shot done");
        // periodic: exact spacing, status, then halt keeps the count
        act(`ITM_CODE_PERIODIC, 3'h1, 32'h9, 32'h6, 0);
        wait_evt;
        wait_evt;
        chk("period_gap", 6 * T, n);
        chk("evt_signal", 9, evt_signal);
        chk("evt_target", 1, evt_target);
        st(3'h1, `ITM_CODE_PERIODIC, 32'hFFFFFFFF, 9, 6);
        act(`ITM_CODE_HALT, 3'h1, 0, 0, 0);
        rd(3'h1);
        repeat (2 * T) @(posedge clk);
        st(3'h1, `ITM_CODE_HALT, held, 0, 0);
        $display("test periodic done");
        // free run from the held value, then reset clears it
        prev = held;
        act(`ITM_CODE_FREERUN, 3'h1, 0, 0, 0);
        repeat (3 * T) @(posedge clk);
        rd(3'h1);
        chk("run_grows", 1, held >= prev + 3 && held <= prev + 4);
        st(3'h1, `ITM_CODE_FREERUN, 32'hFFFFFFFF, 0, 32'hFFFF);
        act(`ITM_CODE_CLEAR, 3'h1, 0, 0, 0);
        st(3'h1, `ITM_CODE_CLEAR, 0, 0, 0);
        act(`ITM_CODE_PERIODIC, 3'h3, 32'hB, 32'h5, 0);
        act(`ITM_CODE_FREERUN, 3'h3, 0, 0, 0);
        st(3'h3, `ITM_CODE_FREERUN, 32'hFFFFFFFF, 0, 32'hFFFF);
        $display("test free-run done");
        // cascaded pairs take the wide range
        act(`ITM_CODE_ONESHOT, 3'h4, 32'h3, 32'h10000, 0);
        st(3'h4, `ITM_CODE_ONESHOT, 32'hFFFFFFFF, 3, 32'h10000);
        act(`ITM_CODE_FREERUN, 3'h5, 0, 0, 0);
        st(3'h5, `ITM_CODE_FREERUN, 32'hFFFFFFFF, 0, 32'hFFFFFFFF);
        act(16'h1005, 3'h2, 0, 0, 1);
        $display("test pairs done");
        test_done;
    end
endmodule // interval_timer_modes_tb_top

// port-level checker attached to every instance of the design
bind itm_top itm_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_target(cmd_target),
    .cmd_signal(cmd_signal), .cmd_period(cmd_period), .read_req(read_req),
    .cmd_done(cmd_done), .cmd_error(cmd_error), .rsp_valid(rsp_valid),
    .rsp_value(rsp_value), .rsp_mode(rsp_mode), .rsp_signal(rsp_signal),
    .rsp_period(rsp_period), .evt_valid(evt_valid), .evt_target(evt_target),
    .evt_signal(evt_signal));
